// File: hdl/ps_config_loader.v
// passive serial configuration sequencer of the programmable device
`timescale 1ns/1ps
`default_nettype none
`include "ps_loader_regs.vh"

module ps_config_loader #(
    parameter [31:0] STREAM_BITS    = `CFG_STREAM_BITS,
    parameter [31:0] RESTART_CYCLES = `CFG_RESTART_CYC
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       config_req_n,
    input  wire       fault_n_in,
    output wire       fault_n_out,
    output reg        fault_n_oe_n_r,
    input  wire       done_in,
    output wire       done_out,
    output reg        done_oe_n_r,
    input  wire       init_done_in,
    output wire       init_done_out,
    output reg        init_done_oe_n_r,
    input  wire       serial_clock_in,
    input  wire       serial_data_in,
    input  wire       user_startup_clock,
    output reg        io_pullup_en_r,
    output reg        io_user_en_r,
    output reg        cfg_error_r,
    output reg  [2:0] state_r
);

    wire [5:0] pins_s;
    wire       req_n_s;
    wire       fault_s;
    wire       done_s;
    wire       sclk_s;
    wire       sdata_s;
    wire       uclk_s;
    wire       init_tick;

    reg        sclk_d_r;
    reg [15:0] shift_r;
    reg [15:0] shift_nxt;
    reg [31:0] bit_cnt_r;
    reg [31:0] bit_cnt_nxt;
    reg [31:0] tmo_cnt_r;
    reg [31:0] tmo_cnt_nxt;
    reg [5:0]  init_cnt_r;
    reg [5:0]  init_cnt_nxt;
    reg        done_seen_r;
    reg        done_seen_nxt;
    reg        opt_init_done_r;
    reg        opt_init_done_nxt;
    reg        opt_user_clk_r;
    reg        opt_user_clk_nxt;
    reg        opt_restart_r;
    reg        opt_restart_nxt;
    reg        err_nxt;
    reg [2:0]  state_nxt;
    reg        od_level_r;
    wire       bit_edge;

    // every pin from outside passes two flops before use
    ps_sync2 #(
        .WIDTH (6)
    ) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   ({config_req_n, fault_n_in, done_in, serial_clock_in,
                 serial_data_in, user_startup_clock}),
        .dout  (pins_s)
    );

    assign req_n_s = pins_s[5];
    assign fault_s = pins_s[4];
    assign done_s  = pins_s[3];
    assign sclk_s  = pins_s[2];
    assign sdata_s = pins_s[1];
    assign uclk_s  = pins_s[0];

    // initialization clock only runs once load-complete is seen high
    ps_init_tick u_init_tick (
        .clk          (clk),
        .rst_n        (rst_n),
        .run          (state_r == `ST_INIT && done_seen_r),
        .use_user_clk (opt_user_clk_r),
        .user_clk_s   (uclk_s),
        .tick_r       (init_tick)
    );

    // serial clock edge memory; data is delayed by the same two stages
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sclk_d_r <= 1'b0;
        else
            sclk_d_r <= sclk_s;
    end

    assign bit_edge = sclk_s & ~sclk_d_r;

    // open-drain pins only ever drive low
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            od_level_r <= 1'b0;
        else
            od_level_r <= 1'b0;
    end

    assign fault_n_out   = od_level_r;
    assign done_out      = od_level_r;
    assign init_done_out = od_level_r;

    // sequencer next state
    always @*
    begin
        state_nxt         = state_r;
        shift_nxt         = shift_r;
        bit_cnt_nxt       = bit_cnt_r;
        tmo_cnt_nxt       = tmo_cnt_r;
        init_cnt_nxt      = init_cnt_r;
        done_seen_nxt     = done_seen_r;
        opt_init_done_nxt = opt_init_done_r;
        opt_user_clk_nxt  = opt_user_clk_r;
        opt_restart_nxt   = opt_restart_r;
        err_nxt           = cfg_error_r;
        case (state_r)
            `ST_RESET:
            begin
                // options and counters start afresh for each request
                shift_nxt         = 16'h0000;
                bit_cnt_nxt       = 32'h0000_0000;
                tmo_cnt_nxt       = 32'h0000_0000;
                init_cnt_nxt      = 6'h00;
                done_seen_nxt     = 1'b0;
                opt_init_done_nxt = 1'b0;
                opt_user_clk_nxt  = 1'b0;
                opt_restart_nxt   = 1'b0;
                if (req_n_s)
                    state_nxt = `ST_WAIT;
            end
            `ST_WAIT:
            begin
                // fault line may still be held by the loader or pull-up lag
                err_nxt = 1'b0;
                // a retry after an error counts the new stream from zero
                shift_nxt     = 16'h0000;
                bit_cnt_nxt   = 32'h0000_0000;
                init_cnt_nxt  = 6'h00;
                done_seen_nxt = 1'b0;
                if (fault_s)
                    state_nxt = `ST_LOAD;
            end
            `ST_LOAD:
            begin
                if (!fault_s)
                begin
                    // loader pulled the shared fault line low
                    err_nxt   = 1'b1;
                    state_nxt = `ST_ERROR;
                end
                else if (bit_edge)
                begin
                    shift_nxt   = {shift_r[14:0], sdata_s};
                    bit_cnt_nxt = bit_cnt_r + 32'h0000_0001;
                    if (bit_cnt_nxt == `CFG_FRAME_BITS)
                    begin
                        // first frame carries the preamble and the options
                        if (shift_nxt[`CFG_PREAMBLE_HI:`CFG_PREAMBLE_LO]
                            != `CFG_PREAMBLE)
                        begin
                            err_nxt   = 1'b1;
                            state_nxt = `ST_ERROR;
                        end
                        else
                        begin
                            opt_init_done_nxt = shift_nxt[`CFG_OPT_INIT_DONE];
                            opt_user_clk_nxt  = shift_nxt[`CFG_OPT_USER_CLK];
                            opt_restart_nxt   = shift_nxt[`CFG_OPT_AUTO_RESTART];
                        end
                    end
                    if (bit_cnt_nxt == STREAM_BITS)
                    begin
                        if (shift_nxt[7:0] == `CFG_POSTAMBLE)
                            state_nxt = `ST_INIT;
                        else
                        begin
                            err_nxt   = 1'b1;
                            state_nxt = `ST_ERROR;
                        end
                    end
                end
            end
            `ST_INIT:
            begin
                // further serial clock edges are ignored here
                if (!fault_s)
                begin
                    err_nxt   = 1'b1;
                    state_nxt = `ST_ERROR;
                end
                else
                begin
                    if (done_s)
                        done_seen_nxt = 1'b1;
                    if (init_tick)
                    begin
                        init_cnt_nxt = init_cnt_r + 6'h01;
                        if (init_cnt_nxt == `CFG_INIT_CLOCKS)
                            state_nxt = `ST_USER;
                    end
                end
            end
            `ST_USER:
            begin
                // only a request pulse leaves user mode
                state_nxt = `ST_USER;
            end
            `ST_ERROR:
            begin
                // without auto-restart the controller must pulse request low
                if (opt_restart_r)
                begin
                    tmo_cnt_nxt = tmo_cnt_r + 32'h0000_0001;
                    if (tmo_cnt_nxt >= RESTART_CYCLES)
                    begin
                        tmo_cnt_nxt = 32'h0000_0000;
                        state_nxt   = `ST_WAIT;
                    end
                end
            end
            default:
            begin
                state_nxt = `ST_RESET;
            end
        endcase
        // request low overrides every state, user mode included
        if (!req_n_s)
            state_nxt = `ST_RESET;
    end

    // state, counters and option latches
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r         <= `ST_RESET;
            shift_r         <= 16'h0000;
            bit_cnt_r       <= 32'h0000_0000;
            tmo_cnt_r       <= 32'h0000_0000;
            init_cnt_r      <= 6'h00;
            done_seen_r     <= 1'b0;
            opt_init_done_r <= 1'b0;
            opt_user_clk_r  <= 1'b0;
            opt_restart_r   <= 1'b0;
            cfg_error_r     <= 1'b0;
        end
        else
        begin
            state_r         <= state_nxt;
            shift_r         <= shift_nxt;
            bit_cnt_r       <= bit_cnt_nxt;
            tmo_cnt_r       <= tmo_cnt_nxt;
            init_cnt_r      <= init_cnt_nxt;
            done_seen_r     <= done_seen_nxt;
            opt_init_done_r <= opt_init_done_nxt;
            opt_user_clk_r  <= opt_user_clk_nxt;
            opt_restart_r   <= opt_restart_nxt;
            cfg_error_r     <= err_nxt;
        end
    end

    // pin enables follow the next state so they change with it
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_n_oe_n_r   <= 1'b0;
            done_oe_n_r      <= 1'b0;
            init_done_oe_n_r <= 1'b1;
            io_pullup_en_r   <= 1'b1;
            io_user_en_r     <= 1'b0;
        end
        else
        begin
            // fault held low in reset and in error
            fault_n_oe_n_r <= !(state_nxt == `ST_RESET ||
                                state_nxt == `ST_ERROR);
            // load-complete released only once the stream checked good
            done_oe_n_r    <= (state_nxt == `ST_INIT ||
                               state_nxt == `ST_USER);
            // init-complete low from option capture to user mode
            init_done_oe_n_r <= !(opt_init_done_nxt &&
                                  (state_nxt == `ST_LOAD ||
                                   state_nxt == `ST_INIT));
            io_pullup_en_r <= (state_nxt != `ST_USER);
            io_user_en_r   <= (state_nxt == `ST_USER);
        end
    end

endmodule // ps_config_loader

`default_nettype wire

// File: hdl/ps_init_tick.v
// initialization clock source: internal oscillator or user start-up clock
`timescale 1ns/1ps
`default_nettype none
`include "ps_loader_regs.vh"

module ps_init_tick (
    input  wire clk,
    input  wire rst_n,
    input  wire run,
    input  wire use_user_clk,
    input  wire user_clk_s,
    output reg  tick_r
);

    reg [`CFG_OSC_DIV_W-1:0] div_r;
    reg                      user_d_r;

    // divider stands still outside initialization
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            div_r <= {`CFG_OSC_DIV_W{1'b0}};
        else if (!run || div_r == `CFG_OSC_LAST)
            div_r <= {`CFG_OSC_DIV_W{1'b0}};
        else
            div_r <= div_r + 1'b1;
    end

    // edge memory of the already synchronised user clock
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            user_d_r <= 1'b0;
        else
            user_d_r <= user_clk_s;
    end

    // one pulse per initialization clock
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_r <= 1'b0;
        else if (!run)
            tick_r <= 1'b0;
        else if (use_user_clk)
            tick_r <= user_clk_s & ~user_d_r;
        else
            tick_r <= (div_r == `CFG_OSC_LAST);
    end

endmodule // ps_init_tick

`default_nettype wire

// File: hdl/ps_sync2.v
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module ps_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // two stages per bit; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_r[i] <= 1'b0;
                    sync_r[i] <= 1'b0;
                end
                else
                begin
                    meta_r[i] <= din[i];
                    sync_r[i] <= meta_r[i];
                end
            end
        end
    endgenerate

    assign dout = sync_r;

endmodule // ps_sync2

`default_nettype wire

// File: pkg/ps_loader_regs.vh
// constants for the passive serial configuration sequencer
`ifndef PS_LOADER_REGS_VH
`define PS_LOADER_REGS_VH

// system clock rate
`define CFG_CLK_MHZ          250
// internal initialization oscillator, typical rate
`define CFG_OSC_MHZ          10
// system clocks per oscillator period
`define CFG_OSC_DIV          (`CFG_CLK_MHZ / `CFG_OSC_MHZ)
`define CFG_OSC_DIV_W        5
// last divider count of one oscillator period, divide ratio minus one
`define CFG_OSC_LAST         5'd24

// initialization clocks after the load-complete line rises
`define CFG_INIT_CLOCKS      6'd40

// longest fault time-out before an automatic restart
`define CFG_RESTART_US       40
`define CFG_RESTART_CYC      (`CFG_RESTART_US * `CFG_CLK_MHZ)

// least low time of the request line the controller must give
`define CFG_REQ_LOW_US       8
`define CFG_REQ_LOW_CYC      (`CFG_REQ_LOW_US * `CFG_CLK_MHZ)

// expected bitstream length in bits
`define CFG_STREAM_BITS      4096

// first frame: preamble in the top byte, option bits in the low byte
`define CFG_FRAME_BITS       16
`define CFG_PREAMBLE_HI      15
`define CFG_PREAMBLE_LO      8
`define CFG_PREAMBLE         8'ha5
`define CFG_OPT_INIT_DONE    0
`define CFG_OPT_USER_CLK     1
`define CFG_OPT_AUTO_RESTART 2

// last byte of the stream must carry this closing pattern
`define CFG_POSTAMBLE        8'h3c

// sequencer states
`define ST_RESET             3'h0
`define ST_WAIT              3'h1
`define ST_LOAD              3'h2
`define ST_INIT              3'h3
`define ST_USER              3'h4
`define ST_ERROR             3'h5

`endif

// File: verification/passive_serial_config_loader_bench.sv
// self-checking bench for the passive serial configuration sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ps_loader_regs.vh"

module passive_serial_config_loader_bench;
    localparam int NB = 64;
    logic          clk, rst_n, req_n, usr_clk;
    logic [NB-1:0] strm;
    logic [2:0]    st;
    logic          f_oe, f_o, d_oe, d_o, i_oe, i_o, m_oe, sck, sda, pu, ue, er;
    logic [2:0]    expq[$];
    int            errors = 0, comparisons = 0, cyc = 0, n;
    // open-drain lines with pull-ups
    wire fault_w = (f_oe | f_o) & m_oe;
    wire done_w  = d_oe | d_o;
    wire idone_w = i_oe | i_o;

    ps_config_loader #(.STREAM_BITS(NB), .RESTART_CYCLES(50)) dut (
        .clk(clk), .rst_n(rst_n), .config_req_n(req_n), .fault_n_in(fault_w),
        .fault_n_out(f_o), .fault_n_oe_n_r(f_oe), .done_in(done_w), .done_out(d_o),
        .done_oe_n_r(d_oe), .init_done_in(idone_w), .init_done_out(i_o),
        .init_done_oe_n_r(i_oe), .serial_clock_in(sck), .serial_data_in(sda),
        .user_startup_clock(usr_clk), .io_pullup_en_r(pu), .io_user_en_r(ue),
        .cfg_error_r(er), .state_r(st));

    ps_loader_memory #(.BITS(NB)) mem (
        .fault_line(fault_w), .select_n(done_w), .stream(strm),
        .sclk(sck), .sdata(sda), .oe_n(m_oe));

    // 250 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk_state(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: state %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t: level %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // stream: preamble, options, random body, closing byte
    function automatic logic [NB-1:0] mk(input logic [7:0] pre, opt, post);
        logic [63:0] r;
        r = {$urandom(), $urandom()};
        return {pre, opt, r[NB-25:0], post};
    endfunction

    // sampled mid-cycle so the edge's updates have landed
    task automatic wait_st(input logic [2:0] s);
        n = 0;
        while (st !== s && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        if (st !== s)
        begin
            errors++;
            $display("ERROR %0t: state %h never reached", $time, s);
        end
    endtask

    task automatic req_pulse();
        @(posedge clk) req_n <= 1'b0;
        repeat (20) @(negedge clk);
        chk_pin(fault_w | done_w | ue, 1'b0);
        repeat (1980) @(posedge clk);
        req_n <= 1'b1;
    endtask

    task automatic uclk(input int k);
        repeat (k)
        begin
            @(posedge clk) usr_clk <= 1'b1;
            repeat (3) @(posedge clk);
            usr_clk <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask

    // each state change takes the oldest expected state
    always @(st)
    begin
        if (rst_n === 1'b1)
            chk_state(st, (expq.size() > 0) ? expq.pop_front() : 3'h7);
    end

    // hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            errors++;
            $display("ERROR %0t: timeout", $time);
            wrap_up();
        end
    end

    initial
    begin
        void'($urandom(10));
        rst_n   = 1'b0;
        req_n   = 1'b0;
        usr_clk = 1'b0;
        strm    = mk(8'ha5, 8'h01, 8'h3c);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(negedge clk);
        chk_pin(fault_w | ~pu, 1'b0);
        // oscillator start-up with init-complete option
        expq = '{`ST_WAIT, `ST_LOAD, `ST_INIT, `ST_USER};
        @(posedge clk) req_n <= 1'b1;
        wait_st(`ST_INIT);
        chk_pin(idone_w, 1'b0);
        repeat (3) @(negedge clk);
        chk_pin(done_w, 1'b1);
        wait_st(`ST_USER);
        chk_pin(n >= 960 && n <= 1015, 1'b1);
        chk_pin(idone_w & ue & ~pu, 1'b1);
        // reconfigure with the user start-up clock, toggled during load too
        strm = mk(8'ha5, 8'h02, 8'h3c);
        expq = '{`ST_RESET, `ST_WAIT, `ST_LOAD, `ST_INIT, `ST_USER};
        req_pulse();
        uclk(100);
        wait_st(`ST_INIT);
        chk_pin(idone_w, 1'b1);
        repeat (6) @(negedge clk);
        uclk(39);
        repeat (10) @(negedge clk);
        chk_state(st, `ST_INIT);
        uclk(1);
        repeat (10) @(negedge clk);
        chk_state(st, `ST_USER);
        // broken closing byte with automatic restart
        strm = mk(8'ha5, 8'h04, 8'h3d);
        expq = '{`ST_RESET, `ST_WAIT, `ST_LOAD, `ST_ERROR, `ST_WAIT, `ST_LOAD, `ST_INIT,
                 `ST_USER};
        req_pulse();
        wait_st(`ST_ERROR);
        chk_pin(er & ~fault_w, 1'b1);
        strm = mk(8'ha5, 8'h04, 8'h3c);
        wait_st(`ST_WAIT);
        chk_pin(n >= 45 && n <= 55, 1'b1);
        wait_st(`ST_USER);
        chk_pin(er, 1'b0);
        // broken preamble, no restart until the controller pulses
        strm = mk(8'h5a, 8'h00, 8'h3c);
        expq = '{`ST_RESET, `ST_WAIT, `ST_LOAD, `ST_ERROR};
        req_pulse();
        wait_st(`ST_ERROR);
        repeat (200) @(negedge clk);
        chk_state(st, `ST_ERROR);
        strm = mk(8'ha5, 8'h00, 8'h3c);
        expq = '{`ST_RESET, `ST_WAIT, `ST_LOAD, `ST_INIT, `ST_USER};
        req_pulse();
        wait_st(`ST_USER);
        chk_pin(expq.size() == 0, 1'b1);
        wrap_up();
    end
endmodule // passive_serial_config_loader_bench

`default_nettype wire

// File: verification/ps_config_loader_properties.sv
// assertions for the passive serial configuration sequencer
`timescale 1ns/1ps
`default_nettype none
`include "ps_loader_regs.vh"

module ps_config_loader_properties #(
    parameter [31:0] STREAM_BITS    = `CFG_STREAM_BITS,
    parameter [31:0] RESTART_CYCLES = `CFG_RESTART_CYC
) (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       config_req_n,
    input wire logic       fault_n_oe_n_r,
    input wire logic       done_oe_n_r,
    input wire logic       init_done_oe_n_r,
    input wire logic       io_pullup_en_r,
    input wire logic       io_user_en_r,
    input wire logic       cfg_error_r,
    input wire logic [2:0] state_r
);
    logic [2:0]  prv_r;
    logic [31:0] dwell_r;

    // cycles spent in the state just left
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prv_r   <= 3'h0;
            dwell_r <= 32'h0;
        end
        else
        begin
            prv_r   <= state_r;
            dwell_r <= (state_r != prv_r) ? 32'h1 : dwell_r + 32'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // one step of the sequencer
    sequence s_step(logic [2:0] a, logic [2:0] b);
        prv_r == a && state_r == b;
    endsequence

    a_req_resets:
        assert property ($fell(config_req_n) |-> ##[1:5] (state_r == `ST_RESET
            && !fault_n_oe_n_r && !done_oe_n_r && !io_user_en_r))
        else $error("request low did not reset");
    a_low_holds:
        assert property (!config_req_n [*5] |-> state_r == `ST_RESET && !fault_n_oe_n_r)
        else $error("left reset with request low");
    a_rise_waits:
        assert property ($rose(config_req_n) |-> ##[1:5] (state_r == `ST_WAIT && fault_n_oe_n_r))
        else $error("fault line not released");
    a_done_after:
        assert property (s_step(`ST_LOAD, `ST_INIT) |-> ##[0:2] done_oe_n_r)
        else $error("load-complete not released");
    a_done_low_load:
        assert property (state_r == `ST_LOAD |-> !done_oe_n_r)
        else $error("load-complete released while loading");
    a_load_length:
        assert property (s_step(`ST_LOAD, `ST_INIT) |-> dwell_r >= (STREAM_BITS - 1) * 6)
        else $error("load ended too early");
    a_init_min:
        assert property (s_step(`ST_INIT, `ST_USER) |-> dwell_r >= 80)
        else $error("initialization too short");
    a_user_pins:
        assert property (s_step(`ST_INIT, `ST_USER)
            |-> io_user_en_r && !io_pullup_en_r && init_done_oe_n_r)
        else $error("user mode outputs wrong");
    a_pullups_kept:
        assert property (state_r != `ST_USER && prv_r != `ST_USER
            |-> io_pullup_en_r && !io_user_en_r)
        else $error("pull-ups dropped outside user mode");
    a_err_pulls:
        assert property ($rose(cfg_error_r)
            |-> !fault_n_oe_n_r && !done_oe_n_r && state_r == `ST_ERROR)
        else $error("error did not pull the fault line");
    a_restart_wait:
        assert property (s_step(`ST_ERROR, `ST_WAIT)
            |-> dwell_r >= RESTART_CYCLES && dwell_r <= RESTART_CYCLES + 2 && fault_n_oe_n_r)
        else $error("restart time-out wrong");
endmodule // ps_config_loader_properties

bind ps_config_loader ps_config_loader_properties #(
    .STREAM_BITS    (STREAM_BITS),
    .RESTART_CYCLES (RESTART_CYCLES)
) props (
    .clk              (clk),
    .rst_n            (rst_n),
    .config_req_n     (config_req_n),
    .fault_n_oe_n_r   (fault_n_oe_n_r),
    .done_oe_n_r      (done_oe_n_r),
    .init_done_oe_n_r (init_done_oe_n_r),
    .io_pullup_en_r   (io_pullup_en_r),
    .io_user_en_r     (io_user_en_r),
    .cfg_error_r      (cfg_error_r),
    .state_r          (state_r)
);

`default_nettype wire

// File: verification/ps_loader_memory.sv
// serial configuration memory model feeding the sequencer
`timescale 1ns/1ps
`default_nettype none

module ps_loader_memory #(
    parameter int BITS = 64
) (
    input  wire logic            fault_line,
    input  wire logic            select_n,
    input  wire logic [BITS-1:0] stream,
    output var  logic            sclk,
    output var  logic            sdata,
    output var  logic            oe_n
);
    // one pass per release of the fault line, dropped on a fault
    initial
    begin
        sclk  = 1'b0;
        sdata = 1'b1;
        oe_n  = 1'b1;
        forever
        begin
            wait (fault_line && !select_n);
            #101;
            for (int i = BITS - 1; i >= 0 && fault_line; i--)
            begin
                sdata = stream[i]; // msb first, set well before the edge
                #24 sclk = 1'b1;
                #24 sclk = 1'b0;
            end
            sdata = 1'b1;
            // clock stands still while waiting; a fault resets the loader at once
            for (int k = 0; k < 16 && fault_line && !select_n; k++)
                #48;
            if (fault_line && !select_n)
                oe_n = 1'b0;
            wait (!fault_line || select_n);
            #200 oe_n = 1'b1;
        end
    end
endmodule // ps_loader_memory

`default_nettype wire
